// [logic/dfst_map.svh]
// Register map, field positions, reset values and counts for the block.
// What this block does
// - Three 8-bit critical limits, one per channel, each reset to 0xa4.
// - Over its critical limit, any channel forces full duty on all fans.
// - Hysteresis remote1 7:4, local 3:0, remote2 7:4 of 0x6e; default 4.
// - Hysteresis fields hold 0 to 15 degrees in one degree steps.
// - Zero hysteresis disables hysteresis; software should not program zero.
// - A running fan stays on until below start less hysteresis.
// - One hysteresis per channel serves fan on/off and critical release.
// - Acoustics bits 7:5: fans 3:1 off or at minimum duty below start.
// - A fan held at minimum duty ignores hysteresis as temperature drops.
// - Three 8-bit operating points, one degree resolution, reset to 0xa4.
// - Per channel 8-bit low and high limits, reset 0x01 and 0x7f.
// - Below the low limit the start temperature is raised.
// - Above the high limit the start temperature is lowered.
// - Events are raised on falling below low and rising above high limit.
// - Above operating point start drops; below it may rise under gates.
// - Each channel runs a short loop every n, a long one every 2n cycles.
// - Codes: remote1 2:0, local 5:3, remote2 7:6 plus bit 0 of 0x36.
// - Code 000 gives 8 and 16 cycles; each step doubles, up to 2048.
// - Short loop above op point less hyst drops start twice the rise.
// - Long loop above the operating point drops start by one more degree.
`ifndef DFST_MAP_SVH
`define DFST_MAP_SVH

`define DFST_ADDR_OP_R1 8'h33
`define DFST_ADDR_OP_LOC 8'h34
`define DFST_ADDR_OP_R2 8'h35
`define DFST_ADDR_LOOP_CTRL_ONE 8'h36
`define DFST_ADDR_LOOP_CTRL_TWO 8'h37
`define DFST_ADDR_LOW_R1 8'h4e
`define DFST_ADDR_HIGH_R1 8'h4f
`define DFST_ADDR_LOW_LOC 8'h50
`define DFST_ADDR_HIGH_LOC 8'h51
`define DFST_ADDR_LOW_R2 8'h52
`define DFST_ADDR_HIGH_R2 8'h53
`define DFST_ADDR_ACOUSTICS 8'h62
`define DFST_ADDR_START_R1 8'h67
`define DFST_ADDR_START_LOC 8'h68
`define DFST_ADDR_START_R2 8'h69
`define DFST_ADDR_CRIT_R1 8'h6a
`define DFST_ADDR_CRIT_LOC 8'h6b
`define DFST_ADDR_CRIT_R2 8'h6c
`define DFST_ADDR_HYST_R1_LOC 8'h6d
`define DFST_ADDR_HYST_R2 8'h6e
`define DFST_ADDR_STATUS_FAN 8'h70
`define DFST_ADDR_STATUS_LIMIT 8'h71

`define DFST_RST_CRIT 8'ha4
`define DFST_RST_OP 8'ha4
`define DFST_RST_LOW 8'h01
`define DFST_RST_HIGH 8'h7f
`define DFST_RST_HYST_R1_LOC 8'h44
`define DFST_RST_HYST_R2 8'h40
`define DFST_RST_ACOUSTICS 8'h00
`define DFST_RST_LOOP_CTRL 8'h00
`define DFST_RST_START 8'h5a

`define DFST_KEEP_MIN_LSB 5
`define DFST_DYN_EN_LSB 5
`define DFST_SHORT_BASE 11'h008

`endif

// [logic/dfst_pkg.sv]
// Types shared by the fan start temperature control block.
package dfst_pkg;

  typedef enum logic [1:0] {
    DFST_FAN_OFF = 2'b00,
    DFST_FAN_MIN = 2'b01,
    DFST_FAN_AUTO = 2'b10,
    DFST_FAN_FULL = 2'b11
  } dfst_fan_mode_t;

  typedef struct packed {
    dfst_fan_mode_t fan_drive_3;
    dfst_fan_mode_t fan_drive_2;
    dfst_fan_mode_t fan_drive_1;
  } dfst_fan_drive_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dfst_reg_req_t;

  typedef struct packed {
    logic [7:0] remote2;
    logic [7:0] local_ch;
    logic [7:0] remote1;
  } dfst_temps_t;

endpackage

// [logic/dfst_control.sv]
// Per-channel critical limit, fan hysteresis and dynamic start temperature.
`timescale 1ns/1ps
`include "dfst_map.svh"

module dfst_control
  import dfst_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire dfst_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire dfst_temps_t temps,
  input wire logic monitor_strobe,
  output dfst_fan_drive_t fan_drive,
  output logic [2:0] low_event,
  output logic [2:0] high_event
);

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  // Saturating arithmetic keeps thresholds from wrapping around.
  function automatic logic [7:0] sub_sat(input logic [7:0] a,
                                         input logic [7:0] b);
    sub_sat = (a > b) ? (a - b) : 8'h00;
  endfunction

  function automatic logic [10:0] short_len(input logic [2:0] code);
    short_len = `DFST_SHORT_BASE << code;
  endfunction

  // The count is widened by one bit so a 2048 long loop still matches.
  function automatic logic [11:0] count_ahead(input logic [10:0] c);
    count_ahead = {1'b0, c} + 12'h001;
  endfunction

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------
  logic [7:0] crit_reg [3];
  logic [7:0] op_reg [3];
  logic [7:0] low_reg [3];
  logic [7:0] high_reg [3];
  logic [7:0] start_reg [3];
  logic [7:0] hyst_r1_loc_reg;
  logic [7:0] hyst_r2_reg;
  logic [7:0] acoustics_reg;
  logic [7:0] loop_one_reg;
  logic [7:0] loop_two_reg;
  logic [10:0] cnt_reg [3];
  logic [7:0] prev_reg [3];
  logic [2:0] crit_active_reg;
  logic [2:0] fan_on_reg;
  logic [2:0] below_low_reg;
  logic [2:0] above_high_reg;
  logic [7:0] temp [3];
  logic [3:0] hyst [3];
  logic [2:0] code [3];
  logic [2:0] dyn_en;
  logic [2:0] keep_min;
  logic code_wr;
  logic [2:0] short_tick;
  logic [2:0] long_tick;

  assign temp[0] = temps.remote1;
  assign temp[1] = temps.local_ch;
  assign temp[2] = temps.remote2;
  assign hyst[0] = hyst_r1_loc_reg[7:4];
  assign hyst[1] = hyst_r1_loc_reg[3:0];
  assign hyst[2] = hyst_r2_reg[7:4];
  assign code[0] = loop_two_reg[2:0];
  assign code[1] = loop_two_reg[5:3];
  assign code[2] = {loop_one_reg[0], loop_two_reg[7:6]};
  assign dyn_en = loop_one_reg[`DFST_DYN_EN_LSB +: 3];
  assign keep_min = acoustics_reg[`DFST_KEEP_MIN_LSB +: 3];
  assign code_wr = reg_req.wr &&
    (reg_req.addr == `DFST_ADDR_LOOP_CTRL_ONE ||
     reg_req.addr == `DFST_ADDR_LOOP_CTRL_TWO);

  // ---------------------------------------------------------------------
  // Software-owned configuration
  // ---------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 3; i++) begin
        crit_reg[i] <= `DFST_RST_CRIT;
        op_reg[i] <= `DFST_RST_OP;
        low_reg[i] <= `DFST_RST_LOW;
        high_reg[i] <= `DFST_RST_HIGH;
      end
      hyst_r1_loc_reg <= `DFST_RST_HYST_R1_LOC;
      hyst_r2_reg <= `DFST_RST_HYST_R2;
      acoustics_reg <= `DFST_RST_ACOUSTICS;
      loop_one_reg <= `DFST_RST_LOOP_CTRL;
      loop_two_reg <= `DFST_RST_LOOP_CTRL;
    end else if (reg_req.wr) begin
      case (reg_req.addr)
        `DFST_ADDR_CRIT_R1: crit_reg[0] <= reg_req.wdata;
        `DFST_ADDR_CRIT_LOC: crit_reg[1] <= reg_req.wdata;
        `DFST_ADDR_CRIT_R2: crit_reg[2] <= reg_req.wdata;
        `DFST_ADDR_OP_R1: op_reg[0] <= reg_req.wdata;
        `DFST_ADDR_OP_LOC: op_reg[1] <= reg_req.wdata;
        `DFST_ADDR_OP_R2: op_reg[2] <= reg_req.wdata;
        `DFST_ADDR_LOW_R1: low_reg[0] <= reg_req.wdata;
        `DFST_ADDR_HIGH_R1: high_reg[0] <= reg_req.wdata;
        `DFST_ADDR_LOW_LOC: low_reg[1] <= reg_req.wdata;
        `DFST_ADDR_HIGH_LOC: high_reg[1] <= reg_req.wdata;
        `DFST_ADDR_LOW_R2: low_reg[2] <= reg_req.wdata;
        `DFST_ADDR_HIGH_R2: high_reg[2] <= reg_req.wdata;
        `DFST_ADDR_HYST_R1_LOC: hyst_r1_loc_reg <= reg_req.wdata;
        `DFST_ADDR_HYST_R2: hyst_r2_reg <= {reg_req.wdata[7:4], 4'h0};
        `DFST_ADDR_ACOUSTICS: acoustics_reg <= reg_req.wdata;
        `DFST_ADDR_LOOP_CTRL_ONE: loop_one_reg <= reg_req.wdata;
        `DFST_ADDR_LOOP_CTRL_TWO: loop_two_reg <= reg_req.wdata;
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Loop period counters
  // ---------------------------------------------------------------------
  // A period code write restarts every counter so no channel runs a
  // partial loop measured against a stale period.
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      short_tick[i] = monitor_strobe &&
        ((count_ahead(cnt_reg[i]) == {1'b0, short_len(code[i])}) ||
         (count_ahead(cnt_reg[i]) == {short_len(code[i]), 1'b0}));
      long_tick[i] = monitor_strobe &&
        (count_ahead(cnt_reg[i]) == {short_len(code[i]), 1'b0});
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 3; i++) begin
        cnt_reg[i] <= 11'h000;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (code_wr) begin
          cnt_reg[i] <= 11'h000;
        end else if (long_tick[i]) begin
          cnt_reg[i] <= 11'h000;
        end else if (monitor_strobe) begin
          cnt_reg[i] <= cnt_reg[i] + 11'h001;
        end
      end
    end
  end

  // ---------------------------------------------------------------------
  // Previous sample and limit events
  // ---------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 3; i++) begin
        prev_reg[i] <= 8'h00;
      end
      below_low_reg <= 3'h0;
      above_high_reg <= 3'h0;
      low_event <= 3'h0;
      high_event <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        low_event[i] <= 1'b0;
        high_event[i] <= 1'b0;
        if (monitor_strobe) begin
          prev_reg[i] <= temp[i];
          below_low_reg[i] <= temp[i] < low_reg[i];
          above_high_reg[i] <= temp[i] > high_reg[i];
          low_event[i] <= (temp[i] < low_reg[i]) &&
            !below_low_reg[i];
          high_event[i] <= (temp[i] > high_reg[i]) &&
            !above_high_reg[i];
        end
      end
    end
  end

  // ---------------------------------------------------------------------
  // Critical limit and fan on/off hysteresis
  // ---------------------------------------------------------------------
  // A zero hysteresis makes the release threshold equal the trip point,
  // which is why fans would cycle between normal and full speed.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      crit_active_reg <= 3'h0;
      fan_on_reg <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (temp[i] > crit_reg[i]) begin
          crit_active_reg[i] <= 1'b1;
        end else if (temp[i] < sub_sat(crit_reg[i], {4'h0, hyst[i]})) begin
          crit_active_reg[i] <= 1'b0;
        end
        if (temp[i] > start_reg[i]) begin
          fan_on_reg[i] <= 1'b1;
        end else if (temp[i] < sub_sat(start_reg[i], {4'h0, hyst[i]})) begin
          fan_on_reg[i] <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------------
  // Dynamic start temperature
  // ---------------------------------------------------------------------
  // Software may rewrite a start temperature at any time; its write wins
  // over a loop update landing in the same cycle.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 3; i++) begin
        start_reg[i] <= `DFST_RST_START;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (reg_req.wr && reg_req.addr == `DFST_ADDR_START_R1 + 8'(i)) begin
          start_reg[i] <= reg_req.wdata;
        end else if (dyn_en[i] && temp[i] > start_reg[i]) begin
          if (long_tick[i] &&
              (temp[i] > op_reg[i] || temp[i] > high_reg[i])) begin
            // Long loop decrement plus any short loop decrement.
            start_reg[i] <= sub_sat(sub_sat(start_reg[i], 8'h01),
              (temp[i] > sub_sat(op_reg[i], {4'h0, hyst[i]}) &&
               temp[i] > prev_reg[i]) ?
              8'((temp[i] - prev_reg[i]) << 1) : 8'h00);
          end else if (short_tick[i] &&
                       temp[i] > sub_sat(op_reg[i], {4'h0, hyst[i]}) &&
                       temp[i] > prev_reg[i]) begin
            start_reg[i] <= sub_sat(start_reg[i],
              8'((temp[i] - prev_reg[i]) << 1));
          end else if (long_tick[i] && temp[i] < low_reg[i] &&
                       start_reg[i] < high_reg[i] &&
                       start_reg[i] < op_reg[i]) begin
            start_reg[i] <= start_reg[i] + 8'h01;
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------------
  // Fan drive decision
  // ---------------------------------------------------------------------
  // Each fan follows the channel of the same index, except that a critical trip on any channel drives every fan full.
  dfst_fan_mode_t mode_next [3];

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      mode_next[i] = DFST_FAN_OFF;
      if (|crit_active_reg) begin
        mode_next[i] = DFST_FAN_FULL;
      end else if (keep_min[i]) begin
        mode_next[i] = (temp[i] > start_reg[i]) ? DFST_FAN_AUTO :
          DFST_FAN_MIN;
      end else if (fan_on_reg[i]) begin
        mode_next[i] = DFST_FAN_AUTO;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fan_drive <= '{DFST_FAN_OFF, DFST_FAN_OFF, DFST_FAN_OFF};
    end else begin
      fan_drive <= '{mode_next[2], mode_next[1], mode_next[0]};
    end
  end

  // ---------------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        `DFST_ADDR_CRIT_R1: reg_rdata <= crit_reg[0];
        `DFST_ADDR_CRIT_LOC: reg_rdata <= crit_reg[1];
        `DFST_ADDR_CRIT_R2: reg_rdata <= crit_reg[2];
        `DFST_ADDR_OP_R1: reg_rdata <= op_reg[0];
        `DFST_ADDR_OP_LOC: reg_rdata <= op_reg[1];
        `DFST_ADDR_OP_R2: reg_rdata <= op_reg[2];
        `DFST_ADDR_LOW_R1: reg_rdata <= low_reg[0];
        `DFST_ADDR_HIGH_R1: reg_rdata <= high_reg[0];
        `DFST_ADDR_LOW_LOC: reg_rdata <= low_reg[1];
        `DFST_ADDR_HIGH_LOC: reg_rdata <= high_reg[1];
        `DFST_ADDR_LOW_R2: reg_rdata <= low_reg[2];
        `DFST_ADDR_HIGH_R2: reg_rdata <= high_reg[2];
        `DFST_ADDR_START_R1: reg_rdata <= start_reg[0];
        `DFST_ADDR_START_LOC: reg_rdata <= start_reg[1];
        `DFST_ADDR_START_R2: reg_rdata <= start_reg[2];
        `DFST_ADDR_HYST_R1_LOC: reg_rdata <= hyst_r1_loc_reg;
        `DFST_ADDR_HYST_R2: reg_rdata <= hyst_r2_reg;
        `DFST_ADDR_ACOUSTICS: reg_rdata <= acoustics_reg;
        `DFST_ADDR_LOOP_CTRL_ONE: reg_rdata <= loop_one_reg;
        `DFST_ADDR_LOOP_CTRL_TWO: reg_rdata <= loop_two_reg;
        `DFST_ADDR_STATUS_FAN: reg_rdata <= {2'h0, fan_on_reg,
                                             crit_active_reg};
        `DFST_ADDR_STATUS_LIMIT: reg_rdata <= {2'h0, above_high_reg,
                                               below_low_reg};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

// [dv/dfst_checker.sv]
// Concurrent checks on the ports of the fan start temperature control block.
`timescale 1ns/1ps
`include "dfst_map.svh"

module dfst_checker
  import dfst_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire dfst_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire dfst_temps_t temps,
  input wire logic monitor_strobe,
  input wire dfst_fan_drive_t fan_drive,
  input wire logic [2:0] low_event,
  input wire logic [2:0] high_event
);
  // ---------------------------------------------------------------
  // Shadow copies of the registers that the checks depend on
  // ---------------------------------------------------------------
  logic [7:0] crit_reg;
  logic keep_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      crit_reg <= `DFST_RST_CRIT;
    end else if (reg_req.wr && reg_req.addr == `DFST_ADDR_CRIT_R1) begin
      crit_reg <= reg_req.wdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      keep_reg <= 1'b0;
    end else if (reg_req.wr && reg_req.addr == `DFST_ADDR_ACOUSTICS) begin
      keep_reg <= reg_req.wdata[5];
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  chk_rdata_idle: assert property (
    !$past(reg_req.rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  chk_crit_readback: assert property (
    $past(reg_req.rd) && $past(reg_req.addr) == `DFST_ADDR_CRIT_R1
    |-> reg_rdata == crit_reg)
    else $error("critical limit read back wrong");
  chk_full_all: assert property (
    (fan_drive.fan_drive_1 == DFST_FAN_FULL ||
     fan_drive.fan_drive_2 == DFST_FAN_FULL ||
     fan_drive.fan_drive_3 == DFST_FAN_FULL) |-> fan_drive == 6'h3f)
    else $error("full speed not applied to every fan");
  // Two edges of latency from temperature to drive, so the cause is two back.
  chk_crit_entry: assert property (
    $past(rst_n, 2) && $past(rst_n) &&
    $past(temps.remote1, 2) > $past(crit_reg, 2) |-> fan_drive == 6'h3f)
    else $error("fans not full above the critical limit");
  chk_low_strobe: assert property (
    (|low_event) |-> $past(monitor_strobe))
    else $error("low event without a monitoring strobe");
  chk_high_strobe: assert property (
    (|high_event) |-> $past(monitor_strobe))
    else $error("high event without a monitoring strobe");
  chk_event_pulse: assert property (
    low_event[0] |=> !low_event[0])
    else $error("low event longer than one cycle");
  chk_keep_never_off: assert property (
    $past(keep_reg, 2) && $past(keep_reg) && keep_reg
    |-> fan_drive.fan_drive_1 != DFST_FAN_OFF)
    else $error("fan 1 off while kept spinning");
  chk_min_needs_keep: assert property (
    fan_drive.fan_drive_1 == DFST_FAN_MIN
    |-> keep_reg || $past(keep_reg) || $past(keep_reg, 2))
    else $error("fan 1 at minimum without keep bit");

  cover property (fan_drive == 6'h3f);
  cover property (low_event[0]);
  cover property (high_event[0]);
  cover property (fan_drive.fan_drive_1 == DFST_FAN_MIN);
endmodule

bind dfst_control dfst_checker i_dfst_checker (
  .mclk(mclk),
  .rst_n(rst_n),
  .reg_req(reg_req),
  .reg_rdata(reg_rdata),
  .temps(temps),
  .monitor_strobe(monitor_strobe),
  .fan_drive(fan_drive),
  .low_event(low_event),
  .high_event(high_event)
);

// [dv/tb.sv]
// Self-checking testbench for the fan start temperature control block.
`timescale 1ns/1ps

module tb;
  import dfst_pkg::*;
  // ---------------------------------------------------------------
  // Signals and design
  // ---------------------------------------------------------------
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  dfst_reg_req_t reg_req = '0;
  logic [7:0] reg_rdata;
  dfst_temps_t temps = {8'h1e, 8'h1e, 8'h1e};
  logic monitor_strobe = 1'b0;
  dfst_fan_drive_t fan_drive;
  logic [2:0] low_event;
  logic [2:0] high_event;
  logic [2:0] low_seen = '0;
  logic [2:0] high_seen = '0;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [7:0] h;
  logic [7:0] ra [23] = '{8'h33, 8'h34, 8'h35, 8'h37, 8'h4e, 8'h4f,
    8'h50, 8'h51, 8'h52, 8'h53, 8'h62, 8'h6a, 8'h6b, 8'h6c, 8'h6d,
    8'h6e, 8'h00, 8'h36, 8'h67, 8'h68, 8'h69, 8'h70, 8'h71};
  logic [7:0] rv [23] = '{8'ha4, 8'ha4, 8'ha4, 8'h00, 8'h01, 8'h7f,
    8'h01, 8'h7f, 8'h01, 8'h7f, 8'h00, 8'ha4, 8'ha4, 8'ha4, 8'h44,
    8'h40, 8'h00, 8'h00, 8'h5a, 8'h5a, 8'h5a, 8'h00, 8'h00};

  always #4 mclk = ~mclk;

  dfst_control i_dfst_control (
    .mclk(mclk),
    .rst_n(rst_n),
    .reg_req(reg_req),
    .reg_rdata(reg_rdata),
    .temps(temps),
    .monitor_strobe(monitor_strobe),
    .fan_drive(fan_drive),
    .low_event(low_event),
    .high_event(high_event)
  );

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_req.wr <= 1'b1;
    reg_req.addr <= a;
    reg_req.wdata <= d;
    @(posedge mclk);
    reg_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_req.rd <= 1'b1;
    reg_req.addr <= a;
    @(posedge mclk);
    reg_req.rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), e, reg_rdata);
  endtask

  // Drive all temperatures, then look at the fans once they settle.
  task automatic tt(input dfst_temps_t t, input logic [5:0] e);
    @(posedge mclk);
    temps <= t;
    repeat (3) @(posedge mclk);
    #1;
    chk("fan drive", {2'b00, e}, {2'b00, fan_drive});
  endtask

  task automatic strobe(input int n);
    repeat (n) begin
      @(posedge mclk);
      monitor_strobe <= 1'b1;
      @(posedge mclk);
      monitor_strobe <= 1'b0;
      #1;
      low_seen = low_seen | low_event;
      high_seen = high_seen | high_event;
    end
  endtask

  // A hang ends the run as a failure instead of stalling forever.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      give_verdict();
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    do_reset();
    for (int i = 0; i < 23; i++) begin
      rd(ra[i], rv[i]);
    end
    for (int i = 0; i < 23; i++) begin
      wr(ra[i], ~ra[i]);
    end
    for (int i = 0; i < 23; i++) begin
      h = (ra[i] == 8'h6e) ? (~ra[i] & 8'hf0) : ~ra[i];
      h = (ra[i] == 8'h00 || ra[i] >= 8'h70) ? 8'h00 : h;
      rd(ra[i], h);
    end
    do_reset();
    wr(8'h6a, 8'h50);
    for (int i = 0; i < 3; i++) begin
      h = (i == 0) ? 8'h04 : ((i == 1) ? 8'h0f : 8'h00);
      wr(8'h6d, {h[3:0], 4'h4});
      tt({8'h1e, 8'h1e, 8'h51}, 6'h3f);
      tt({8'h1e, 8'h1e, 8'h50 - h}, 6'h3f);
      tt({8'h1e, 8'h1e, 8'h4f - h}, 6'h00);
    end
    wr(8'h6b, 8'h50);
    tt({8'h1e, 8'h51, 8'h1e}, 6'h3f);
    tt({8'h1e, 8'h1e, 8'h1e}, 6'h00);
    do_reset();
    tt({8'h1e, 8'h1e, 8'h5b}, 6'h02);
    tt({8'h1e, 8'h1e, 8'h57}, 6'h02);
    tt({8'h1e, 8'h1e, 8'h55}, 6'h00);
    wr(8'h62, 8'h20);
    tt({8'h1e, 8'h1e, 8'h55}, 6'h01);
    tt({8'h1e, 8'h1e, 8'h5b}, 6'h02);
    tt({8'h1e, 8'h1e, 8'h59}, 6'h01);
    wr(8'h62, 8'he0);
    tt({8'h1e, 8'h1e, 8'h1e}, 6'h15);
    tt({8'h1e, 8'h5b, 8'h1e}, 6'h19);
    do_reset();
    tt({8'h1e, 8'h1e, 8'h3c}, 6'h00);
    wr(8'h33, 8'h32);
    wr(8'h67, 8'h28);
    wr(8'h36, 8'h20);
    strobe(2);
    wr(8'h37, 8'h00);
    strobe(15);
    rd(8'h67, 8'h28);
    strobe(1);
    rd(8'h67, 8'h27);
    strobe(7);
    @(posedge mclk);
    temps.remote1 <= 8'h3e;
    strobe(1);
    rd(8'h67, 8'h23);
    wr(8'h37, 8'h01);
    strobe(31);
    rd(8'h67, 8'h23);
    strobe(1);
    rd(8'h67, 8'h22);
    wr(8'h33, 8'h50);
    wr(8'h4e, 8'h46);
    wr(8'h37, 8'h00);
    strobe(16);
    rd(8'h67, 8'h23);
    chk("low event", 8'h01, {5'h00, low_seen});
    wr(8'h4f, 8'h3c);
    strobe(16);
    rd(8'h67, 8'h22);
    chk("high event", 8'h01, {5'h00, high_seen});
    give_verdict();
  end
endmodule
